// File: shared/dsm_pkg.sv
// Constants for the decoder / serial clock pin multiplexer.
// Assumes one clock domain; pin order is port C pins 4..7, then port E pin 4.
package dsm_pkg;
  // ---------------------------------------------------------------
  // Pin layout
  // ---------------------------------------------------------------
  localparam int PIN_COUNT = 5;
  localparam int PORT_C_PINS = 4;
  localparam int SCK_IDX = 4;
  localparam int PORT_C_BIT_LO = 4;
  localparam int PORT_E_SCK_BIT = 4;
  localparam int PULLUP_WIDTH = 8;
  localparam int FUNC_WIDTH = 2;

  // ---------------------------------------------------------------
  // Function select codes
  // ---------------------------------------------------------------
  typedef logic [1:0] dsm_func_t;
  localparam dsm_func_t FUNC_PERIPH = 2'h0;
  localparam dsm_func_t FUNC_TIMER = 2'h1;
  localparam dsm_func_t FUNC_GPIO = 2'h2;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] PULLUP_RESET = 8'h00ff;
  localparam logic [7:0] FUNC_C_RESET = 8'h0000;
  localparam logic FUNC_E_GPIO_RESET = 1'b0;
  localparam logic [4:0] DIR_RESET = 5'h00;
  localparam logic [4:0] GPIO_DATA_RESET = 5'h00;
  localparam logic [4:0] PIN_IDLE = 5'h1f;
endpackage

// File: shared/dsm_cfg_if.sv
// Carries configuration state and filtered pin levels between mux modules.
// Assumes all parties run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface dsm_cfg_if;
  logic [7:0] pullup_c;
  logic [7:0] pullup_e;
  logic [7:0] func_c;
  logic func_e_gpio;
  logic [4:0] dir;
  logic [4:0] gpio_data;
  logic [4:0] level;
  modport regs (output pullup_c, pullup_e, func_c, func_e_gpio, dir, gpio_data);
  modport sync (output level);
  modport user (input pullup_c, pullup_e, func_c, func_e_gpio, dir, gpio_data, level);
endinterface
`default_nettype wire

// File: core/dsm_pin_sync.sv
// Three-stage input filter for the pad levels.
// Assumes pad inputs are asynchronous to clock_i.
`timescale 1ns/1ns
`default_nettype none
module dsm_pin_sync
  import dsm_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [4:0] pad_in_i,
  dsm_cfg_if.sync pins
);
  logic [4:0] stage1;
  logic [4:0] stage2;
  logic [4:0] stage3;
  logic [4:0] level;

  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++)
    begin : g_bit
      always_ff @(posedge clock_i)
      begin
        if (rst_i)
        begin
          stage1[g] <= PIN_IDLE[g];
          stage2[g] <= PIN_IDLE[g];
          stage3[g] <= PIN_IDLE[g];
          level[g] <= PIN_IDLE[g];
        end
        else
        begin
          stage1[g] <= pad_in_i[g];
          stage2[g] <= stage1[g];
          stage3[g] <= stage2[g];
          // Accept a change only once two stages agree
          if (stage2[g] == stage3[g])
            level[g] <= stage3[g];
        end
      end
    end
  endgenerate

  assign pins.level = level;
endmodule
`default_nettype wire

// File: core/dsm_cfg_regs.sv
// Configuration state: function selects, direction, data, pull-ups.
// Assumes write strobes are single-cycle from logic on clock_i.
`timescale 1ns/1ns
`default_nettype none
module dsm_cfg_regs
  import dsm_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic func_we_i,
  input wire logic [7:0] func_c_i,
  input wire logic func_e_gpio_i,
  input wire logic dir_we_i,
  input wire logic [4:0] dir_mask_i,
  input wire logic [4:0] dir_i,
  input wire logic data_we_i,
  input wire logic [4:0] data_i,
  input wire logic pullup_c_we_i,
  input wire logic [7:0] pullup_c_i,
  input wire logic pullup_e_we_i,
  input wire logic [7:0] pullup_e_i,
  dsm_cfg_if.regs cfg
);
  logic [7:0] pullup_c;
  logic [7:0] pullup_e;
  logic [7:0] func_c;
  logic func_e_gpio;
  logic [4:0] dir;
  logic [4:0] gpio_data;
  logic [4:0] next_dir;

  // Per-pin masked direction update
  assign next_dir = (dir & ~dir_mask_i) | (dir_i & dir_mask_i);

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      pullup_c <= PULLUP_RESET;
      pullup_e <= PULLUP_RESET;
      func_c <= FUNC_C_RESET;
      func_e_gpio <= FUNC_E_GPIO_RESET;
      dir <= DIR_RESET;
      gpio_data <= GPIO_DATA_RESET;
    end
    else
    begin
      if (pullup_c_we_i)
        pullup_c <= pullup_c_i;
      if (pullup_e_we_i)
        pullup_e <= pullup_e_i;
      if (func_we_i)
      begin
        func_c <= func_c_i;
        func_e_gpio <= func_e_gpio_i;
      end
      if (dir_we_i)
        dir <= next_dir;
      if (data_we_i)
        gpio_data <= data_i;
    end
  end

  assign cfg.pullup_c = pullup_c;
  assign cfg.pullup_e = pullup_e;
  assign cfg.func_c = func_c;
  assign cfg.func_e_gpio = func_e_gpio;
  assign cfg.dir = dir;
  assign cfg.gpio_data = gpio_data;
endmodule
`default_nettype wire

// File: core/dsm_pin_mux.sv
// Pin multiplexer for the four decoder pins and the serial clock pin.
// Assumes pads resolve level from out/oe and apply pull-ups externally.
//
// How it works
// - GPIO direction set per pin independently
// - Reset selects decoder phase A on C4
// - Reset selects decoder phase B on C5
// - Reset selects decoder index on C6
// - Reset selects decoder home on C7
// - Reset selects serial clock on E4
// - Port C bit 4 zero: phase A pull-up off
// - Port C bit 5 zero: phase B pull-up off
// - Port C bit 6 zero: index pull-up off
// - Port C bit 7 zero: home pull-up off
// - Port E bit 4 zero: clock pull-up off
// - Master mode drives serial clock pin out
// - Slave mode takes serial clock as input
`timescale 1ns/1ns
`default_nettype none
module dsm_pin_mux
  import dsm_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [4:0] pad_in_i,
  output logic [4:0] pad_out_o,
  output logic [4:0] pad_oe_o,
  output logic [4:0] pad_pullup_o,
  input wire logic func_we_i,
  input wire logic [7:0] func_c_i,
  input wire logic func_e_gpio_i,
  input wire logic dir_we_i,
  input wire logic [4:0] dir_mask_i,
  input wire logic [4:0] dir_i,
  input wire logic data_we_i,
  input wire logic [4:0] data_i,
  input wire logic pullup_c_we_i,
  input wire logic [7:0] pullup_c_i,
  input wire logic pullup_e_we_i,
  input wire logic [7:0] pullup_e_i,
  input wire logic spi_master_i,
  input wire logic spi_clock_out_i,
  input wire logic [3:0] timer_out_i,
  input wire logic [3:0] timer_oe_i,
  output logic decoder_phase_a_in_o,
  output logic decoder_phase_b_in_o,
  output logic decoder_index_in_o,
  output logic decoder_home_in_o,
  output logic spi_clock_in_o,
  output logic [3:0] timer_in_o,
  output logic [4:0] gpio_level_o,
  output logic [7:0] func_c_o,
  output logic func_e_gpio_o,
  output logic [4:0] dir_o,
  output logic [7:0] pullup_c_o,
  output logic [7:0] pullup_e_o
);
  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  dsm_cfg_if cfg ();

  dsm_cfg_regs u_regs (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .func_we_i(func_we_i),
    .func_c_i(func_c_i),
    .func_e_gpio_i(func_e_gpio_i),
    .dir_we_i(dir_we_i),
    .dir_mask_i(dir_mask_i),
    .dir_i(dir_i),
    .data_we_i(data_we_i),
    .data_i(data_i),
    .pullup_c_we_i(pullup_c_we_i),
    .pullup_c_i(pullup_c_i),
    .pullup_e_we_i(pullup_e_we_i),
    .pullup_e_i(pullup_e_i),
    .cfg(cfg.regs)
  );

  dsm_pin_sync u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .pad_in_i(pad_in_i),
    .pins(cfg.sync)
  );

  // ---------------------------------------------------------------
  // Per-pin selection decode
  // ---------------------------------------------------------------
  logic [4:0] is_periph;
  logic [4:0] is_timer;
  logic [4:0] is_gpio;
  logic [4:0] next_out;
  logic [4:0] next_oe;
  logic [4:0] next_pullup;
  logic [3:0] next_timer_in;
  logic [3:0] next_decoder;
  logic [4:0] next_gpio_level;
  logic next_spi_clock_in;
  logic sck_drive;

  genvar g;
  generate
    for (g = 0; g < PORT_C_PINS; g++)
    begin : g_port_c
      wire dsm_func_t sel = cfg.func_c[FUNC_WIDTH*g +: FUNC_WIDTH];
      // Decoder function is input only
      assign is_periph[g] = (sel == FUNC_PERIPH);
      assign is_timer[g] = (sel == FUNC_TIMER);
      assign is_gpio[g] = !is_periph[g] && !is_timer[g];
      assign next_oe[g] = is_timer[g] ? timer_oe_i[g]
                        : (is_gpio[g] & cfg.dir[g]);
      assign next_out[g] = is_timer[g] ? timer_out_i[g] : cfg.gpio_data[g];
      assign next_pullup[g] = cfg.pullup_c[PORT_C_BIT_LO + g];
      assign next_timer_in[g] = is_timer[g] ? cfg.level[g] : 1'b0;
      // Unselected decoder inputs idle at the pulled-up level
      assign next_decoder[g] = is_periph[g] ? cfg.level[g] : 1'b1;
    end
  endgenerate

  // Serial clock pin: no timer function on port E
  assign is_periph[SCK_IDX] = !cfg.func_e_gpio;
  assign is_timer[SCK_IDX] = 1'b0;
  assign is_gpio[SCK_IDX] = cfg.func_e_gpio;
  assign sck_drive = is_periph[SCK_IDX] && spi_master_i;
  assign next_oe[SCK_IDX] = sck_drive
                          | (is_gpio[SCK_IDX] & cfg.dir[SCK_IDX]);
  assign next_out[SCK_IDX] = sck_drive ? spi_clock_out_i
                           : cfg.gpio_data[SCK_IDX];
  assign next_pullup[SCK_IDX] = cfg.pullup_e[PORT_E_SCK_BIT];
  // Slave takes the external clock; master and GPIO read low
  assign next_spi_clock_in = is_periph[SCK_IDX] && !spi_master_i
                           ? cfg.level[SCK_IDX] : 1'b0;
  assign next_gpio_level = cfg.level;

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      pad_out_o <= GPIO_DATA_RESET;
      pad_oe_o <= DIR_RESET;
      pad_pullup_o <= PIN_IDLE;
      timer_in_o <= 4'h0;
      decoder_phase_a_in_o <= 1'b1;
      decoder_phase_b_in_o <= 1'b1;
      decoder_index_in_o <= 1'b1;
      decoder_home_in_o <= 1'b1;
      spi_clock_in_o <= 1'b0;
      gpio_level_o <= PIN_IDLE;
    end
    else
    begin
      pad_out_o <= next_out;
      pad_oe_o <= next_oe;
      pad_pullup_o <= next_pullup;
      timer_in_o <= next_timer_in;
      decoder_phase_a_in_o <= next_decoder[0];
      decoder_phase_b_in_o <= next_decoder[1];
      decoder_index_in_o <= next_decoder[2];
      decoder_home_in_o <= next_decoder[3];
      spi_clock_in_o <= next_spi_clock_in;
      gpio_level_o <= next_gpio_level;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      func_c_o <= FUNC_C_RESET;
      func_e_gpio_o <= FUNC_E_GPIO_RESET;
      dir_o <= DIR_RESET;
      pullup_c_o <= PULLUP_RESET;
      pullup_e_o <= PULLUP_RESET;
    end
    else
    begin
      func_c_o <= cfg.func_c;
      func_e_gpio_o <= cfg.func_e_gpio;
      dir_o <= cfg.dir;
      pullup_c_o <= cfg.pullup_c;
      pullup_e_o <= cfg.pullup_e;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  // Decoder outputs gathered per pin
  logic [3:0] dec_seen;
  assign dec_seen = {decoder_home_in_o, decoder_index_in_o,
                     decoder_phase_b_in_o, decoder_phase_a_in_o};

  chk_phase_a_default: assert property (
    $fell(rst_i) |-> cfg.func_c[1:0] == FUNC_PERIPH
      ##1 decoder_phase_a_in_o == $past(cfg.level[0]))
    else $error("C4 not on phase A after reset");

  chk_phase_b_default: assert property (
    $fell(rst_i) |-> cfg.func_c[3:2] == FUNC_PERIPH)
    else $error("C5 not on phase B after reset");

  chk_index_default: assert property (
    $fell(rst_i) |-> cfg.func_c[5:4] == FUNC_PERIPH && !pad_oe_o[2])
    else $error("C6 not on index after reset");

  chk_home_default: assert property (
    $fell(rst_i) |-> cfg.func_c[7:6] == FUNC_PERIPH && !pad_oe_o[3])
    else $error("C7 not on home after reset");

  chk_sck_default: assert property (
    $fell(rst_i) |-> !cfg.func_e_gpio && pad_pullup_o[SCK_IDX])
    else $error("E4 not on serial clock after reset");

  generate
    for (g = 0; g < PORT_C_PINS; g++)
    begin : g_chk
      chk_pullup_c_off: assert property (
        pullup_c_we_i && !pullup_c_i[PORT_C_BIT_LO + g] && !rst_i
          |-> ##2 !pad_pullup_o[g])
        else $error("Port C pull-up still on after clear");

      chk_timer_route: assert property (
        cfg.func_c[2*g +: 2] == FUNC_TIMER
          |=> pad_oe_o[g] == $past(timer_oe_i[g])
              && pad_out_o[g] == $past(timer_out_i[g]))
        else $error("Timer function not routed to pin");

      chk_periph_input: assert property (
        is_periph[g] |=> !pad_oe_o[g] && dec_seen[g] == $past(cfg.level[g]))
        else $error("Decoder pin not taken as input");

      chk_decoder_idle: assert property (
        !is_periph[g] |=> dec_seen[g])
        else $error("Unselected decoder input not idle");

      chk_timer_in: assert property (
        is_timer[g] |=> timer_in_o[g] == $past(cfg.level[g]))
        else $error("Timer input not taken from pin");

      chk_gpio_drive: assert property (
        is_gpio[g] |=> pad_oe_o[g] == $past(cfg.dir[g])
          && pad_out_o[g] == $past(cfg.gpio_data[g]))
        else $error("GPIO pin not driven from its own bits");

      chk_pullup_c_on: assert property (
        pullup_c_we_i && pullup_c_i[PORT_C_BIT_LO + g] |-> ##2 pad_pullup_o[g])
        else $error("Port C pull-up not on after set");
    end
  endgenerate

  chk_pullup_e_off: assert property (
    pullup_e_we_i && !pullup_e_i[PORT_E_SCK_BIT] |-> ##2 !pad_pullup_o[SCK_IDX])
    else $error("Serial clock pull-up still on after clear");

  chk_pullup_e_on: assert property (
    pullup_e_we_i && pullup_e_i[PORT_E_SCK_BIT] |-> ##2 pad_pullup_o[SCK_IDX])
    else $error("Serial clock pull-up not on after set");

  chk_sck_gpio: assert property (
    cfg.func_e_gpio |=> pad_oe_o[SCK_IDX] == $past(cfg.dir[SCK_IDX])
      && pad_out_o[SCK_IDX] == $past(cfg.gpio_data[SCK_IDX]) && !spi_clock_in_o)
    else $error("Port E pin not under GPIO control");

  chk_sck_master: assert property (
    !cfg.func_e_gpio && spi_master_i
      |=> pad_oe_o[SCK_IDX] && pad_out_o[SCK_IDX] == $past(spi_clock_out_i))
    else $error("Master does not drive serial clock");

  chk_sck_slave: assert property (
    !cfg.func_e_gpio && !spi_master_i
      |=> !pad_oe_o[SCK_IDX] && spi_clock_in_o == $past(cfg.level[SCK_IDX]))
    else $error("Slave serial clock not taken as input");

  chk_dir_masked: assert property (
    dir_we_i && !dir_mask_i[0] && cfg.func_c[1:0] == FUNC_GPIO
      |=> cfg.dir[0] == $past(cfg.dir[0]) ##1 pad_oe_o[0] == $past(cfg.dir[0], 2))
    else $error("Direction of unmasked pin changed");

  // ---------------------------------------------------------------
  // Per-pin direction checks
  // ---------------------------------------------------------------
  generate
    for (g = 0; g < PIN_COUNT; g++)
    begin : g_chk_dir
      chk_dir_taken: assert property (
        dir_we_i && dir_mask_i[g] |=> cfg.dir[g] == $past(dir_i[g]))
        else $error("Masked direction bit not written");

      chk_dir_kept: assert property (
        !(dir_we_i && dir_mask_i[g]) |=> cfg.dir[g] == $past(cfg.dir[g]))
        else $error("Direction bit changed without its mask");
    end
  endgenerate

  cov_master: cover property (!cfg.func_e_gpio && spi_master_i ##1 pad_oe_o[SCK_IDX]);
  cov_slave: cover property (!cfg.func_e_gpio && !spi_master_i ##1 $rose(spi_clock_in_o));
  cov_gpio_out: cover property (is_gpio[1] && cfg.dir[1] ##1 pad_oe_o[1]);
  cov_timer: cover property (is_timer[2] && timer_oe_i[2] ##1 pad_oe_o[2]);
  cov_pullup_off: cover property (pullup_c_we_i && !pullup_c_i[PORT_C_BIT_LO] ##2 !pad_pullup_o[0]);
endmodule
`default_nettype wire

// File: bench/dsm_pin_mux_test.sv
// Self-checking bench for the decoder / serial clock pin multiplexer.
// Assumes dsm_pkg and dsm_cfg_if are compiled first; no partner model.
`timescale 1ns/1ns
`default_nettype none
module dsm_pin_mux_test
  import dsm_pkg::*;
;
  logic clock_i, rst_i, func_we_i, func_e_gpio_i, dir_we_i, data_we_i;
  logic pullup_c_we_i, pullup_e_we_i, spi_master_i, spi_clock_out_i;
  logic [7:0] func_c_i, pullup_c_i, pullup_e_i, func_c_o, pullup_c_o, pullup_e_o;
  logic [4:0] pad_in_i, dir_mask_i, dir_i, data_i, pad_out_o, pad_oe_o, pad_pullup_o;
  logic [4:0] gpio_level_o, dir_o;
  logic [3:0] timer_out_i, timer_oe_i, timer_in_o;
  logic ph_a, ph_b, idx, home, spi_clock_in_o, func_e_gpio_o;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [4:0] exp_dir;

  dsm_pin_mux dut (.clock_i(clock_i), .rst_i(rst_i), .pad_in_i(pad_in_i),
    .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .pad_pullup_o(pad_pullup_o),
    .func_we_i(func_we_i), .func_c_i(func_c_i), .func_e_gpio_i(func_e_gpio_i),
    .dir_we_i(dir_we_i), .dir_mask_i(dir_mask_i), .dir_i(dir_i), .data_we_i(data_we_i),
    .data_i(data_i), .pullup_c_we_i(pullup_c_we_i), .pullup_c_i(pullup_c_i),
    .pullup_e_we_i(pullup_e_we_i), .pullup_e_i(pullup_e_i), .spi_master_i(spi_master_i),
    .spi_clock_out_i(spi_clock_out_i), .timer_out_i(timer_out_i), .timer_oe_i(timer_oe_i),
    .decoder_phase_a_in_o(ph_a), .decoder_phase_b_in_o(ph_b), .decoder_index_in_o(idx),
    .decoder_home_in_o(home), .spi_clock_in_o(spi_clock_in_o), .timer_in_o(timer_in_o),
    .gpio_level_o(gpio_level_o), .func_c_o(func_c_o), .func_e_gpio_o(func_e_gpio_o),
    .dir_o(dir_o), .pullup_c_o(pullup_c_o), .pullup_e_o(pullup_e_o));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Write strobes: taken at edge N, visible after edge N+1
  task automatic wr_func(input logic [7:0] c, input logic e);
    func_c_i = c;
    func_e_gpio_i = e;
    func_we_i = 1'b1;
    tick(1);
    func_we_i = 1'b0;
    tick(1);
  endtask

  task automatic wr_pull(input logic port_e, input logic [7:0] v);
    pullup_c_i = v;
    pullup_e_i = v;
    pullup_c_we_i = !port_e;
    pullup_e_we_i = port_e;
    tick(1);
    pullup_c_we_i = 1'b0;
    pullup_e_we_i = 1'b0;
    tick(1);
  endtask

  task automatic wr_dir(input logic [4:0] mask, input logic [4:0] d);
    dir_mask_i = mask;
    dir_i = d;
    dir_we_i = 1'b1;
    tick(1);
    dir_we_i = 1'b0;
    tick(1);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    check("func_c", func_c_o, 8'h00);
    check("func_e", {7'h0, func_e_gpio_o}, 8'h00);
    check("pad_oe", {3'h0, pad_oe_o}, 8'h00);
    check("pullup", {3'h0, pad_pullup_o}, 8'h1f);
    check("pull_e", pullup_e_o, 8'hff);
    pad_in_i = 5'h15;
    tick(6);
    check("decoders", {4'h0, home, idx, ph_b, ph_a}, 8'h05);
    check("timer_in", {4'h0, timer_in_o}, 8'h00);
    check("sck_in", {7'h0, spi_clock_in_o}, 8'h01);
    check("level", {3'h0, gpio_level_o}, 8'h15);
    $display("Test reset defaults done");
  endtask

  task automatic t_pullups();
    for (int b = 0; b < 4; b++)
    begin
      wr_pull(1'b0, 8'hff ^ (8'h10 << b));
      check("pull_c_pin", {3'h0, pad_pullup_o}, 8'h1f ^ (8'h01 << b));
      check("pull_c", pullup_c_o, 8'hff ^ (8'h10 << b));
    end
    wr_pull(1'b0, 8'hff);
    wr_pull(1'b1, 8'hef);
    check("pull_e_pin", {3'h0, pad_pullup_o}, 8'h0f);
    wr_pull(1'b1, 8'hff);
    $display("Test pull-ups done");
  endtask

  task automatic t_timer();
    wr_func(8'h55, 1'b0);
    timer_oe_i = 4'h9;
    timer_out_i = 4'h3;
    pad_in_i = 5'h0a;
    tick(6);
    check("tmr_oe", {4'h0, pad_oe_o[3:0]}, 8'h09);
    check("tmr_out", {4'h0, pad_out_o[3:0]}, 8'h03);
    check("tmr_in", {4'h0, timer_in_o}, 8'h0a);
    check("dec_idle", {4'h0, home, idx, ph_b, ph_a}, 8'h0f);
    $display("Test timer select done");
  endtask

  // Reset in mid-run after the setup has been changed
  task automatic t_rereset();
    wr_pull(1'b0, 8'h0f);
    pad_in_i = 5'h0a;
    rst_i = 1'b1;
    tick(3);
    rst_i = 1'b0;
    tick(1);
    check("rst_func_c", func_c_o, 8'h00);
    check("rst_func_e", {7'h0, func_e_gpio_o}, 8'h00);
    check("rst_oe", {3'h0, pad_oe_o}, 8'h00);
    check("rst_dir", {3'h0, dir_o}, 8'h00);
    check("rst_pull", pullup_c_o, 8'hff);
    tick(6);
    check("rst_dec", {4'h0, home, idx, ph_b, ph_a}, 8'h0a);
    check("rst_sck_in", {7'h0, spi_clock_in_o}, 8'h00);
    $display("Test reset mid-run done");
  endtask

  task automatic t_gpio();
    wr_func(8'hee, 1'b1);
    data_i = 5'h15;
    data_we_i = 1'b1;
    tick(1);
    data_we_i = 1'b0;
    exp_dir = 5'h00;
    for (int p = 0; p < 5; p++)
    begin
      wr_dir(5'h01 << p, 5'h1f);
      exp_dir[p] = 1'b1;
      check("dir", {3'h0, dir_o}, {3'h0, exp_dir});
      check("gpio_oe", {3'h0, pad_oe_o}, {3'h0, exp_dir});
    end
    wr_dir(5'h04, 5'h00);
    check("dir_one", {3'h0, pad_oe_o}, 8'h1b);
    check("gpio_out", {3'h0, pad_out_o & pad_oe_o}, 8'h11);
    check("dec_gpio", {3'h0, spi_clock_in_o, home, idx, ph_b, ph_a}, 8'h0f);
    $display("Test gpio direction done");
  endtask

  task automatic t_spi();
    wr_func(8'h00, 1'b0);
    spi_master_i = 1'b1;
    spi_clock_out_i = 1'b1;
    pad_in_i = 5'h1f;
    tick(6);
    check("m_oe", {7'h0, pad_oe_o[4]}, 8'h01);
    check("m_out", {7'h0, pad_out_o[4]}, 8'h01);
    check("m_in", {7'h0, spi_clock_in_o}, 8'h00);
    spi_clock_out_i = 1'b0;
    tick(2);
    check("m_out0", {7'h0, pad_out_o[4]}, 8'h00);
    spi_master_i = 1'b0;
    tick(6);
    check("s_oe", {7'h0, pad_oe_o[4]}, 8'h00);
    check("s_in1", {7'h0, spi_clock_in_o}, 8'h01);
    pad_in_i = 5'h0f;
    tick(6);
    check("s_in0", {7'h0, spi_clock_in_o}, 8'h00);
    $display("Test serial clock modes done");
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    rst_i = 1'b1;
    {func_we_i, func_e_gpio_i, dir_we_i, data_we_i, pullup_c_we_i, pullup_e_we_i} = '0;
    {spi_master_i, spi_clock_out_i, func_c_i, pullup_c_i, pullup_e_i} = '0;
    {dir_mask_i, dir_i, data_i, timer_out_i, timer_oe_i} = '0;
    pad_in_i = 5'h1f;
    tick(16);
    rst_i = 1'b0;
    tick(1);
    t_reset();
    t_pullups();
    t_timer();
    t_gpio();
    t_rereset();
    t_spi();
    conclude();
  end

  initial
  begin
    #20000;
    n_mismatch++;
    conclude();
  end
endmodule
`default_nettype wire
